// ===== hw/pas_pcm_port.sv
`timescale 1ns/1ps
`default_nettype none

module pas_pcm_port #(
    parameter int DEPTH = pas_pkg::FIFO_DEPTH,
    parameter int WIDTH = pas_pkg::SAMPLE_BITS
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic txValid,
    output logic txReady,
    input wire logic [WIDTH-1:0] txData,
    output logic rxValid,
    input wire logic rxReady,
    output logic [WIDTH-1:0] rxData,
    output logic rxOverrun,
    output logic pcmClk,
    output logic pcmSync,
    output logic pcmOut,
    output logic pcmOutOe,
    input wire logic pcmIn
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

    // ------------------------------------------------------------
    // Reset release.
    // ------------------------------------------------------------
    logic [1:0] rstPipeQ;
    logic rstSyncN;
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            rstPipeQ <= 2'h0;
        else
            rstPipeQ <= {rstPipeQ[0], 1'b1};
    end
    assign rstSyncN = rstPipeQ[1];

    // ------------------------------------------------------------
    // Bit and slot timing.
    // ------------------------------------------------------------
    logic [pas_pkg::DIV_W-1:0] divQ;
    logic [pas_pkg::SLOT_W-1:0] slotQ;
    logic bitEnd;
    logic fallNext;
    assign bitEnd = (divQ == pas_pkg::DIV_LAST);
    assign fallNext = (divQ == pas_pkg::DIV_FALL_PRE);

    always_ff @(posedge sys_clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            divQ <= '0;
            slotQ <= pas_pkg::SLOT_LAST;
        end
        else if (bitEnd)
        begin
            divQ <= '0;
            slotQ <= slotQ + 8'h01;
        end
        else
            divQ <= divQ + 7'h01;
    end

    // The clock is produced here, so it carries no second domain.
    always_ff @(posedge sys_clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
            pcmClk <= 1'b0;
        else if (bitEnd)
            pcmClk <= 1'b1;
        else if (fallNext)
            pcmClk <= 1'b0;
    end

    always_ff @(posedge sys_clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
            pcmSync <= 1'b0;
        else if (divQ == pas_pkg::DIV_SYNC_PRE)
            pcmSync <= (slotQ == pas_pkg::SLOT_SYNC);
    end

    // ------------------------------------------------------------
    // Transmit buffer and serializer.
    // ------------------------------------------------------------
    logic [WIDTH-1:0] txMemQ [DEPTH];
    logic [PW-1:0] txWrQ;
    logic [PW-1:0] txRdQ;
    logic [CW-1:0] txCntQ;
    logic txPush;
    logic txPop;
    logic frameLoad;
    logic [WIDTH-1:0] txShQ;
    assign txReady = (txCntQ != CNT_FULL);
    assign txPush = txValid && txReady;
    assign frameLoad = bitEnd && (slotQ == pas_pkg::SLOT_LAST);
    assign txPop = frameLoad && (txCntQ != '0);

    always_ff @(posedge sys_clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            txWrQ <= '0;
            txRdQ <= '0;
            txCntQ <= '0;
        end
        else
        begin
            if (txPush)
                txWrQ <= (txWrQ == PTR_LAST) ? '0 : txWrQ + PW'(1);
            if (txPop)
                txRdQ <= (txRdQ == PTR_LAST) ? '0 : txRdQ + PW'(1);
            txCntQ <= txCntQ + CW'(txPush) - CW'(txPop);
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (txPush)
            txMemQ[txWrQ] <= txData;
    end

    // An empty buffer at frame start sends silence rather than stale data.
    // The last bit is held through the low phase and released at the next rise.
    // Releasing on the sampling fall itself would leave the codec no hold time.
    always_ff @(posedge sys_clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            txShQ <= '0;
            pcmOut <= 1'b0;
            pcmOutOe <= 1'b0;
        end
        else if (frameLoad)
            txShQ <= txPop ? txMemQ[txRdQ] : '0;
        else if (bitEnd && slotQ < pas_pkg::SLOT_DATA_LAST)
        begin
            pcmOut <= txShQ[WIDTH-1];
            pcmOutOe <= 1'b1;
            txShQ <= {txShQ[WIDTH-2:0], 1'b0};
        end
        else if (bitEnd && slotQ == pas_pkg::SLOT_DATA_LAST)
        begin
            pcmOut <= 1'b0;
            pcmOutOe <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Receive sampler and buffer.
    // ------------------------------------------------------------
    logic inS1Q;
    logic inS2Q;
    logic inS3Q;
    logic inQ;
    always_ff @(posedge sys_clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            inS1Q <= 1'b0;
            inS2Q <= 1'b0;
            inS3Q <= 1'b0;
            inQ <= 1'b0;
        end
        else
        begin
            inS1Q <= pcmIn;
            inS2Q <= inS1Q;
            inS3Q <= inS2Q;
            if (inS2Q == inS3Q)
                inQ <= inS3Q;
        end
    end

    // Sampling a few cycles ahead of the fall offsets the synchroniser delay,
    // so the pin is read inside its setup window before the falling edge.
    logic [WIDTH-1:0] rxShQ;
    logic rxPush;
    logic rxPop;
    logic rxAccept;
    logic [WIDTH-1:0] rxMemQ [DEPTH];
    logic [PW-1:0] rxWrQ;
    logic [PW-1:0] rxRdQ;
    logic [CW-1:0] rxCntQ;
    assign rxPush = fallNext && (slotQ == pas_pkg::SLOT_DATA_LAST);
    assign rxPop = rxValid && rxReady;
    assign rxValid = (rxCntQ != '0);
    assign rxAccept = rxPush && ((rxCntQ != CNT_FULL) || rxPop);

    always_ff @(posedge sys_clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
            rxShQ <= '0;
        else if (divQ == pas_pkg::DIV_IN_SAMPLE && slotQ >= pas_pkg::SLOT_FIRST
                 && slotQ <= pas_pkg::SLOT_DATA_LAST)
            rxShQ <= {rxShQ[WIDTH-2:0], inQ};
    end

    always_ff @(posedge sys_clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            rxWrQ <= '0;
            rxRdQ <= '0;
            rxCntQ <= '0;
            rxOverrun <= 1'b0;
        end
        else
        begin
            if (rxAccept)
                rxWrQ <= (rxWrQ == PTR_LAST) ? '0 : rxWrQ + PW'(1);
            if (rxPop)
                rxRdQ <= (rxRdQ == PTR_LAST) ? '0 : rxRdQ + PW'(1);
            rxCntQ <= rxCntQ + CW'(rxAccept) - CW'(rxPop);
            rxOverrun <= rxPush && !rxAccept;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rxAccept)
            rxMemQ[rxWrQ] <= rxShQ;
    end
    assign rxData = rxMemQ[rxRdQ];

    // ------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------
    logic [7:0] clkRunQ;
    logic [11:0] oeRunQ;
    logic [17:0] frameRunQ;
    logic frameSeenQ;
    always_ff @(posedge sys_clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            clkRunQ <= '0;
            oeRunQ <= '0;
            frameRunQ <= '0;
            frameSeenQ <= 1'b0;
        end
        else
        begin
            clkRunQ <= (pcmClk != $past(pcmClk)) ? 8'h01 : ((clkRunQ == 8'h00) ? 8'h00 : clkRunQ + 8'h01);
            oeRunQ <= pcmOutOe ? oeRunQ + 12'h001 : 12'h000;
            frameRunQ <= $rose(pcmSync) ? 18'h00001 : frameRunQ + 18'h00001;
            if ($rose(pcmSync))
                frameSeenQ <= 1'b1;
        end
    end

    a_clk_phase_len: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
        $changed(pcmClk) && clkRunQ > 8'h01 |-> clkRunQ == 8'(pas_pkg::HALF_CYC))
        else $error("bit clock phase length wrong");
    a_sync_lead: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
        $rose(pcmSync) |-> ##30 $fell(pcmClk))
        else $error("sync lead before falling edge wrong");
    a_sync_width: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
        $rose(pcmSync) |-> ##1 (pcmSync [*8]) ##114 $fell(pcmSync))
        else $error("sync width not one bit period");
    a_frame_period: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
        $rose(pcmSync) && frameSeenQ |-> frameRunQ == 18'(pas_pkg::BIT_CYC * pas_pkg::FRAME_BITS))
        else $error("frame period wrong");
    a_out_launch: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
        $changed(pcmOut) && pcmOutOe |-> $rose(pcmClk))
        else $error("output bit not launched on rising edge");
    a_out_release: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
        $fell(pcmOutOe) |-> $rose(pcmClk))
        else $error("output not released after falling edge");
    a_sample_bits: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
        $fell(pcmOutOe) |-> oeRunQ == 12'(pas_pkg::SAMPLE_BITS * pas_pkg::BIT_CYC))
        else $error("output drive span not sixteen bits");
    a_in_capture: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
        rxPush |-> ##1 $fell(pcmClk))
        else $error("input word not closed at falling edge");
    a_tx_full: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
        txCntQ == CNT_FULL |-> !txReady ##1 (txCntQ <= CNT_FULL))
        else $error("transmit buffer overfilled");
endmodule : pas_pcm_port

`default_nettype wire

// ===== inc/pas_pkg.sv
package pas_pkg;
    // ------------------------------------------------------------
    // Timing of the serial link.
    // ------------------------------------------------------------
    localparam int SYS_CLK_NS = 4;
    localparam int BIT_HIGH_NS = 244;
    localparam int BIT_LOW_NS = 244;
    localparam int SYNC_LEAD_NS = 122;
    localparam int HALF_CYC = BIT_HIGH_NS / SYS_CLK_NS;
    localparam int BIT_CYC = HALF_CYC + BIT_LOW_NS / SYS_CLK_NS;
    // A longest lead rounds down to whole cycles.
    localparam int LEAD_CYC = SYNC_LEAD_NS / SYS_CLK_NS;
    localparam int FRAME_BITS = 256;
    localparam int SAMPLE_BITS = 16;
    localparam int DIV_W = 7;
    localparam int SLOT_W = 8;
    // The input synchroniser runs this many cycles behind the pin.
    localparam int IN_SYNC_LAT = 3;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(BIT_CYC - 1);
    localparam logic [DIV_W-1:0] DIV_FALL_PRE = DIV_W'(HALF_CYC - 1);
    localparam logic [DIV_W-1:0] DIV_SYNC_PRE = DIV_W'(HALF_CYC - LEAD_CYC - 1);
    localparam logic [DIV_W-1:0] DIV_IN_SAMPLE = DIV_W'(HALF_CYC - 1 - IN_SYNC_LAT);
    localparam logic [SLOT_W-1:0] SLOT_LAST = SLOT_W'(FRAME_BITS - 1);
    localparam logic [SLOT_W-1:0] SLOT_SYNC = 8'h00;
    localparam logic [SLOT_W-1:0] SLOT_FIRST = 8'h01;
    localparam logic [SLOT_W-1:0] SLOT_DATA_LAST = SLOT_W'(SAMPLE_BITS);
    localparam int FIFO_DEPTH = 2;
endpackage : pas_pkg

// ===== dv/pas_codec_model.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Codec slave: takes bit clock and sync as inputs.
// ------------------------------------------------------------
module pas_codec_model (
    input wire logic pcmClk,
    input wire logic pcmSync,
    input wire logic pcmOut,
    input wire logic pcmOutOe,
    output logic pcmIn,
    output logic [15:0] lastRx,
    output int count,
    output logic oeSeen
);
    logic [15:0] sendWord = 16'hc35a;
    logic [15:0] shiftIn = 16'h0000;
    int bitNo = 0;
    initial
    begin
        pcmIn = 1'b0;
        lastRx = 16'h0000;
        count = 0;
        oeSeen = 1'b1;
    end
    always @(negedge pcmClk)
    begin
        if (bitNo >= 1 && bitNo <= 16)
        begin
            shiftIn = {shiftIn[14:0], pcmOut};
            oeSeen = oeSeen & pcmOutOe;
            bitNo++;
            if (bitNo == 17)
            begin
                lastRx = shiftIn;
                count++;
                sendWord = sendWord + 16'h1111;
                bitNo = 0;
            end
        end
        else if (pcmSync)
            bitNo = 1;
    end
    // Outside its slots the line toggles, so a stale bit cannot pass for data.
    always @(posedge pcmClk)
    begin
        if (bitNo >= 1 && bitNo <= 16)
            pcmIn <= sendWord[16 - bitNo];
        else
            pcmIn <= ~pcmIn;
    end
endmodule : pas_codec_model

`default_nettype wire

// ===== dv/pas_pcm_port_bench.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
    $display("ERROR %s expected %h seen %h", n, e, g); end end

module pas_pcm_port_bench;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic txValid = 1'b0;
    logic txReady, rxValid, rxOverrun, pcmClk, pcmSync, pcmOut, pcmOutOe, pcmIn, oeSeen;
    logic rxReady = 1'b0;
    logic [15:0] txData = 16'h0000;
    logic [15:0] rxData, lastRx;
    int count, fail_count = 0, check_count = 0, cycles = 0, ovr = 0;

    always #2 sys_clk = ~sys_clk;

    pas_pcm_port DUT (.sys_clk(sys_clk), .rstn(rstn), .txValid(txValid), .txReady(txReady),
        .txData(txData), .rxValid(rxValid), .rxReady(rxReady), .rxData(rxData),
        .rxOverrun(rxOverrun), .pcmClk(pcmClk), .pcmSync(pcmSync), .pcmOut(pcmOut),
        .pcmOutOe(pcmOutOe), .pcmIn(pcmIn));
    pas_codec_model codec (.pcmClk(pcmClk), .pcmSync(pcmSync), .pcmOut(pcmOut),
        .pcmOutOe(pcmOutOe), .pcmIn(pcmIn), .lastRx(lastRx), .count(count), .oeSeen(oeSeen));

    // ------------------------------------------------------------
    // Closing and watchdog.
    // ------------------------------------------------------------
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish

    always @(negedge sys_clk)
    begin
        cycles++;
        if (rxOverrun === 1'b1)
            ovr++;
        if (cycles == 80000)
        begin
            fail_count++;
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------
    task automatic t_txfill;
        @(negedge sys_clk) txValid = 1'b1;
        txData = 16'h9e21;
        @(negedge sys_clk) txData = 16'h4b7d;
        @(negedge sys_clk) txData = 16'hffff;
        repeat (3) @(negedge sys_clk) `CHK("txReady full", 1'b0, txReady)
        txValid = 1'b0;
    endtask : t_txfill

    task automatic t_timing;
        realtime t0, t1, t2;
        @(posedge pcmSync) t0 = $realtime;
        @(negedge pcmClk) `CHK("sync lead", 30, int'(($realtime - t0) / 4))
        @(negedge pcmSync) `CHK("sync width", 122, int'(($realtime - t0) / 4))
        @(posedge pcmClk) t1 = $realtime;
        @(negedge pcmClk) t2 = $realtime;
        `CHK("clk high", 61, int'((t2 - t1) / 4))
        @(posedge pcmClk) `CHK("clk period", 122, int'(($realtime - t1) / 4))
        @(posedge pcmSync) `CHK("frame", 31232, int'(($realtime - t0) / 4))
    endtask : t_timing

    task automatic t_frame(input int n, input logic [15:0] expOut, input logic expValid,
        input logic [15:0] expHead, input int expOvr);
        while (count < n)
            @(negedge sys_clk);
        repeat (pas_pkg::HALF_CYC + 4) @(negedge sys_clk);
        `CHK("codec word", expOut, lastRx)
        `CHK("oe in slots", 1'b1, oeSeen)
        `CHK("oe released", 1'b0, pcmOutOe)
        `CHK("rxValid", expValid, rxValid)
        `CHK("rxData", expHead, rxData)
        `CHK("overrun", expOvr, ovr)
    endtask : t_frame

    task automatic t_drain;
        @(negedge sys_clk) rxReady = 1'b1;
        @(negedge sys_clk) `CHK("rx second", 16'hd46b, rxData)
        @(negedge sys_clk) rxReady = 1'b0;
        `CHK("rx empty", 1'b0, rxValid)
    endtask : t_drain

    initial
    begin
        repeat (16) @(negedge sys_clk);
        rstn = 1'b1;
        repeat (3) @(negedge sys_clk);
        t_txfill();
        t_frame(1, 16'h9e21, 1'b1, 16'hc35a, 0);
        t_timing();
        t_frame(2, 16'h4b7d, 1'b1, 16'hc35a, 0);
        // An empty transmit buffer sends zeros; the full receive side drops the word.
        t_frame(3, 16'h0000, 1'b1, 16'hc35a, 1);
        t_drain();
        tally_and_finish();
    end
endmodule : pas_pcm_port_bench

`default_nettype wire
